// *** pkg/sfbf_map.vh ***
/*
  Constants of the serial flash bus front end: register offsets, control and
  dummy field positions, reset values, command codes and operation times.
  Assumes inclusion by its bare name from every design file that needs it.
*/
`ifndef SFBF_MAP_VH
`define SFBF_MAP_VH

// ==========================================================================
// register offsets (byte addresses on the apb bus)
`define SFBF_OFF_CTRL 12'h000
`define SFBF_OFF_DUMMY 12'h004
`define SFBF_OFF_STAT 12'h008
`define SFBF_OFF_ADDR 12'h00c
`define SFBF_OFF_UIDL 12'h010
`define SFBF_OFF_UIDH 12'h014

// ==========================================================================
// control register fields
`define SFBF_CB_QE 0
`define SFBF_CB_FOUR 1
`define SFBF_CB_CONT 2
`define SFBF_CB_WRAP 3
`define SFBF_CB_WSEL 4
`define SFBF_CB_L3RST 6
`define SFBF_CB_EXTA 7
`define SFBF_CB_LOCK 8
`define SFBF_CTRL_RST 11'h000

// ==========================================================================
// dummy cycle fields, four bits each
`define SFBF_DF_FAST 0
`define SFBF_DF_DIO 4
`define SFBF_DF_QIO 8
`define SFBF_DF_WQIO 12
`define SFBF_DUMMY_RST 16'h4648

// ==========================================================================
// command codes
`define SFBF_OP_FREAD 8'h0b
`define SFBF_OP_DOUT 8'h3b
`define SFBF_OP_QOUT 8'h6b
`define SFBF_OP_DIO 8'hbb
`define SFBF_OP_QIO 8'heb
`define SFBF_OP_WQIO 8'he7
`define SFBF_OP_PROG 8'h02
`define SFBF_OP_SE4K 8'h20
`define SFBF_OP_BE32K 8'h52
`define SFBF_OP_BE64K 8'hd8
`define SFBF_OP_CHIP 8'hc7
`define SFBF_OP_UID 8'h4b
`define SFBF_OP_SECRD 8'h48
`define SFBF_OP_SECPRG 8'h42

// ==========================================================================
// internal operation times and clock rate
`define SFBF_CLK_MHZ 34'h0000007d
`define SFBF_T_PROG_US 34'h0000001f4
`define SFBF_T_SECT_US 34'h000009c40
`define SFBF_T_B32_US 34'h00001d4c0
`define SFBF_T_B64_US 34'h00003d090
`define SFBF_T_CHIP_US 34'h005f5e100

`endif

// *** rtl/_unused_placeholder_none.v ***
/*
  Empty file kept out of the build.
  Assumes nothing.
*/
`timescale 1ns/1ps

// *** rtl/sfbf_busy_timer.v ***
/*
  Down-counter that models an internal erase or program operation.
  Assumes start is a one-cycle pulse and load is at least one.
*/
`timescale 1ns/1ps
module sfbf_busy_timer (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [33:0] load,
  output reg busy
);
  reg [33:0] left;

  // nothing here looks at select: a started operation always runs out
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 34'h000000000;
      busy <= 1'b0;
    end else if (start && !busy) begin
      left <= load;
      busy <= 1'b1;
    end else if (busy) begin
      left <= left - 34'h000000001;
      if (left == 34'h000000001) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // sfbf_busy_timer

// *** rtl/sfbf_front_end.v ***
/*
  Serial flash bus front end: samples select, serial clock and four data
  lanes, decodes commands and moves bytes to and from an array port, with an
  apb register file for configuration and status.
  Assumes the serial clock runs well below a quarter of clk, mem_rdata is
  valid one clk after mem_addr changes, and the apb master is on clk.
*/
`timescale 1ns/1ps
`include "sfbf_map.vh"
module sfbf_front_end #(
  parameter [63:0] UID_VALUE = 64'h0123456789abcdef, // arbitrary value
  parameter [33:0] T_PROG_CYC = `SFBF_T_PROG_US * `SFBF_CLK_MHZ,
  parameter [33:0] T_SECT_CYC = `SFBF_T_SECT_US * `SFBF_CLK_MHZ,
  parameter [33:0] T_B32_CYC = `SFBF_T_B32_US * `SFBF_CLK_MHZ,
  parameter [33:0] T_B64_CYC = `SFBF_T_B64_US * `SFBF_CLK_MHZ,
  parameter [33:0] T_CHIP_CYC = `SFBF_T_CHIP_US * `SFBF_CLK_MHZ
) (
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sclk_pin,
  input wire select_n_pin,
  input wire data_lane_0_in,
  input wire data_lane_1_in,
  input wire data_lane_2_in,
  input wire data_lane_3_in,
  output reg data_lane_0_out,
  output reg data_lane_1_out,
  output reg data_lane_2_out,
  output reg data_lane_3_out,
  output reg data_lane_0_oe_n,
  output reg data_lane_1_oe_n,
  output reg data_lane_2_oe_n,
  output reg data_lane_3_oe_n,
  output reg [24:0] mem_addr,
  output reg [1:0] mem_region,
  input wire [7:0] mem_rdata,
  output reg wr_valid,
  output reg [7:0] wr_data,
  output reg erase_start,
  output reg [2:0] erase_size,
  output wire busy
);
  // ========================================================================
  // states and command kinds
  localparam S_IDLE = 3'd0, S_OPC = 3'd1, S_DEC = 3'd2, S_ADDR = 3'd3;
  localparam S_DUMMY = 3'd4, S_RDATA = 3'd5, S_WDATA = 3'd6, S_DONE = 3'd7;
  localparam K_NONE = 3'd0, K_READ = 3'd1, K_UID = 3'd2, K_PROG = 3'd3;
  localparam K_ERASE = 3'd4, K_SRD = 3'd5, K_SPRG = 3'd6;

  function [24:0] shin;
    input [24:0] v;
    input [1:0] w;
    input [3:0] b;
    begin
      case (w)
        2'd0: shin = {v[23:0], b[0]};
        2'd1: shin = {v[22:0], b[1:0]};
        default: shin = {v[20:0], b};
      endcase
    end
  endfunction

  // ========================================================================
  // reset and pin synchronisers
  wire rst_n;
  wire [5:0] pin_s;
  sfbf_sync #(.W(1)) u_rst (.clk(clk), .rst_n(arst_n), .d(1'b1), .q(rst_n));
  sfbf_sync #(.W(6)) u_pins (
    .clk(clk),
    .rst_n(rst_n),
    .d({sclk_pin, select_n_pin, data_lane_3_in, data_lane_2_in,
        data_lane_1_in, data_lane_0_in}),
    .q(pin_s)
  );
  wire sclk_s = pin_s[5];
  wire sel_n_s = pin_s[4];
  wire [3:0] lane_s = pin_s[3:0];

  reg [10:0] ctrl;
  reg [15:0] dummy_cfg;
  wire qe = ctrl[`SFBF_CB_QE];
  wire four = ctrl[`SFBF_CB_FOUR] & qe;
  // with quad enable set lane 3 is pure data: no pause, no reset
  wire paused = ~sel_n_s & ~qe & ~ctrl[`SFBF_CB_L3RST] & ~lane_s[3];
  wire lane_rst = ~qe & ctrl[`SFBF_CB_L3RST] & ~lane_s[3];
  reg sclk_q, sel_q, armed;
  // the previous clock level is tracked even while paused or deselected, so
  // a mode 3 idle-high clock at select fall makes no phantom edge
  wire rise = sclk_s & ~sclk_q & ~sel_n_s & ~paused;
  wire fall = ~sclk_s & sclk_q & ~sel_n_s & ~paused;
  wire sel_fall = sel_q & ~sel_n_s;
  wire sel_rise = ~sel_q & sel_n_s;

  // ========================================================================
  // command decode
  reg [7:0] opc, last_opc;
  reg [2:0] st, kind, d_kind, d_esize, esize;
  reg [1:0] aw, dw, d_aw, d_dw;
  reg [3:0] dmy, d_dmy;
  reg d_ok;
  always @* begin
    d_kind = K_NONE;
    d_aw = 2'd0;
    d_dw = 2'd0;
    d_dmy = dummy_cfg[`SFBF_DF_FAST +: 4];
    d_esize = 3'd0;
    d_ok = 1'b1;
    case (opc)
      `SFBF_OP_FREAD: d_kind = K_READ;
      `SFBF_OP_DOUT: begin d_kind = K_READ; d_dw = 2'd1; end
      `SFBF_OP_QOUT: begin d_kind = K_READ; d_dw = 2'd2; d_ok = qe; end
      `SFBF_OP_DIO: begin
        d_kind = K_READ; d_aw = 2'd1; d_dw = 2'd1;
        d_dmy = dummy_cfg[`SFBF_DF_DIO +: 4];
      end
      `SFBF_OP_QIO: begin
        d_kind = K_READ; d_aw = 2'd2; d_dw = 2'd2; d_ok = qe;
        d_dmy = dummy_cfg[`SFBF_DF_QIO +: 4];
      end
      `SFBF_OP_WQIO: begin
        d_kind = K_READ; d_aw = 2'd2; d_dw = 2'd2; d_ok = qe;
        d_dmy = dummy_cfg[`SFBF_DF_WQIO +: 4];
      end
      `SFBF_OP_PROG: d_kind = K_PROG;
      `SFBF_OP_SE4K: begin d_kind = K_ERASE; d_esize = 3'd1; end
      `SFBF_OP_BE32K: begin d_kind = K_ERASE; d_esize = 3'd2; end
      `SFBF_OP_BE64K: begin d_kind = K_ERASE; d_esize = 3'd3; end
      `SFBF_OP_CHIP: begin d_kind = K_ERASE; d_esize = 3'd4; end
      `SFBF_OP_UID: d_kind = K_UID;
      `SFBF_OP_SECRD: d_kind = K_SRD;
      `SFBF_OP_SECPRG: d_kind = K_SPRG;
      default: d_ok = 1'b0;
    endcase
    if (four) begin
      d_aw = 2'd2;
      d_dw = 2'd2;
    end
  end

  // ========================================================================
  // shifting and addressing helpers
  reg [24:0] sr;
  reg [4:0] cnt;
  reg [7:0] rd_sr;
  reg [8:0] wcount;
  reg cont_active, op_armed, wrote;
  wire [1:0] wcur = (st == S_OPC) ? (four ? 2'd2 : 2'd0) : (st == S_ADDR) ? aw : dw;
  wire [3:0] ins_bits = lane_s;
  wire [24:0] sh = shin(sr, wcur, ins_bits);
  wire [4:0] need = (st == S_ADDR) ? (5'd24 >> wcur) : (5'd8 >> wcur);
  wire last_edge = (cnt == need - 5'd1);
  wire [1:0] wsel = ctrl[`SFBF_CB_WSEL +: 2];
  wire [7:0] wmask = 8'h3f >> (2'd3 - wsel);
  wire [24:0] amask = (kind == K_UID) ? 25'h0000007 :
    (kind == K_PROG || kind == K_SPRG || kind == K_SRD) ? 25'h00000ff :
    ctrl[`SFBF_CB_WRAP] ? {17'h00000, wmask} : 25'h1ffffff;
  wire [24:0] next_addr = (mem_addr & ~amask) | ((mem_addr + 25'h0000001) & amask);
  wire [63:0] uid_sh = UID_VALUE << {mem_addr[2:0], 3'b000};
  wire [7:0] src_byte = (kind == K_UID) ? uid_sh[63:56] : mem_rdata;
  wire [7:0] out_byte = (cnt == 5'd0) ? src_byte : rd_sr;
  wire [24:0] full_addr = {ctrl[`SFBF_CB_EXTA], sh[23:0]};
  wire [1:0] sec_idx = sh[9:8];
  wire [24:0] ealign = (esize == 3'd1) ? 25'h1fff000 :
    (esize == 3'd2) ? 25'h1ff8000 : 25'h1ff0000;
  wire busy_refuse = busy & (d_kind == K_PROG || d_kind == K_ERASE || d_kind == K_SPRG);
  reg tmr_start;
  reg [33:0] tmr_load;

  sfbf_busy_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .load(tmr_load),
    .busy(busy)
  );

  // ========================================================================
  // serial command engine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE; sclk_q <= 1'b0; sel_q <= 1'b0; armed <= 1'b0;
      opc <= 8'h00; last_opc <= 8'h00; kind <= K_NONE; aw <= 2'd0; dw <= 2'd0;
      dmy <= 4'h0; esize <= 3'd0; sr <= 25'h0000000; cnt <= 5'd0; rd_sr <= 8'h00;
      wcount <= 9'h000; cont_active <= 1'b0; op_armed <= 1'b0; wrote <= 1'b0;
      mem_addr <= 25'h0000000; mem_region <= 2'd0; wr_valid <= 1'b0;
      wr_data <= 8'h00; erase_start <= 1'b0; erase_size <= 3'd0;
      tmr_start <= 1'b0; tmr_load <= 34'h000000001;
      {data_lane_3_out, data_lane_2_out, data_lane_1_out, data_lane_0_out} <= 4'h0;
      {data_lane_3_oe_n, data_lane_2_oe_n, data_lane_1_oe_n, data_lane_0_oe_n} <= 4'hf;
    end else begin
      sclk_q <= sclk_s;
      sel_q <= sel_n_s;
      wr_valid <= 1'b0;
      erase_start <= 1'b0;
      tmr_start <= 1'b0;
      if (sel_n_s) begin
        armed <= 1'b1;
      end
      if (wr_valid) begin
        mem_addr <= next_addr;
      end
      if (!ctrl[`SFBF_CB_CONT]) begin
        cont_active <= 1'b0;
      end
      if (sel_n_s || paused || lane_rst) begin
        // floats on deselect, pause or lane reset, whatever the state
        {data_lane_3_oe_n, data_lane_2_oe_n, data_lane_1_oe_n, data_lane_0_oe_n} <= 4'hf;
      end
      if (lane_rst) begin
        st <= S_IDLE;
        cont_active <= 1'b0;
        op_armed <= 1'b0;
      end else if (sel_rise) begin
        st <= S_IDLE;
        op_armed <= 1'b0;
        if (op_armed) begin
          tmr_start <= 1'b1;
          erase_start <= (kind == K_ERASE);
          erase_size <= esize;
          tmr_load <= (kind != K_ERASE) ? T_PROG_CYC : (esize == 3'd1) ? T_SECT_CYC :
            (esize == 3'd2) ? T_B32_CYC : (esize == 3'd3) ? T_B64_CYC : T_CHIP_CYC;
        end
      end else if (sel_fall && armed) begin
        cnt <= 5'd0;
        wrote <= 1'b0;
        wcount <= 9'h000;
        st <= (cont_active && ctrl[`SFBF_CB_CONT]) ? S_ADDR : S_OPC;
      end else begin
        case (st)
          S_OPC: if (rise) begin
            sr <= sh;
            cnt <= last_edge ? 5'd0 : cnt + 5'd1;
            opc <= sh[7:0];
            if (last_edge) st <= S_DEC;
          end
          S_DEC: begin
            last_opc <= opc;
            kind <= d_kind; aw <= d_aw; dw <= d_dw; dmy <= d_dmy; esize <= d_esize;
            mem_region <= 2'd0;
            cont_active <= 1'b0;
            if (!d_ok || busy_refuse) begin
              st <= S_DONE;
            end else if (d_kind == K_UID) begin
              mem_addr <= 25'h0000000;
              st <= (d_dmy == 4'h0) ? S_RDATA : S_DUMMY;
            end else if (d_esize == 3'd4) begin
              mem_addr <= 25'h0000000;
              op_armed <= 1'b1;
              st <= S_DONE;
            end else begin
              st <= S_ADDR;
            end
          end
          S_ADDR: if (rise) begin
            sr <= sh;
            cnt <= last_edge ? 5'd0 : cnt + 5'd1;
            if (last_edge) begin
              mem_addr <= full_addr;
              if (kind == K_SRD || kind == K_SPRG) begin
                mem_region <= sec_idx + 2'd1;
                if (sec_idx == 2'd3 || (kind == K_SPRG && ctrl[`SFBF_CB_LOCK + sec_idx])) begin
                  st <= S_DONE;
                end else begin
                  st <= (kind == K_SPRG) ? S_WDATA : (dmy == 4'h0) ? S_RDATA : S_DUMMY;
                end
              end else if (kind == K_ERASE) begin
                mem_addr <= full_addr & ealign;
                op_armed <= 1'b1;
                st <= S_DONE;
              end else if (kind == K_PROG) begin
                st <= S_WDATA;
              end else begin
                st <= (dmy == 4'h0) ? S_RDATA : S_DUMMY;
              end
            end
          end
          S_DUMMY: if (rise) begin
            cnt <= (cnt == {1'b0, dmy} - 5'd1) ? 5'd0 : cnt + 5'd1;
            if (cnt == {1'b0, dmy} - 5'd1) st <= S_RDATA;
          end
          S_RDATA: if (fall) begin
            rd_sr <= (dw == 2'd0) ? {out_byte[6:0], 1'b0} :
              (dw == 2'd1) ? {out_byte[5:0], 2'b00} : {out_byte[3:0], 4'h0};
            cnt <= last_edge ? 5'd0 : cnt + 5'd1;
            if (cnt == 5'd0) mem_addr <= next_addr;
            if (opc == `SFBF_OP_QIO && ctrl[`SFBF_CB_CONT]) cont_active <= 1'b1;
            case (dw)
              2'd0: begin
                data_lane_1_out <= out_byte[7];
                data_lane_1_oe_n <= 1'b0;
              end
              2'd1: begin
                {data_lane_1_out, data_lane_0_out} <= out_byte[7:6];
                {data_lane_1_oe_n, data_lane_0_oe_n} <= 2'b00;
              end
              default: begin
                {data_lane_3_out, data_lane_2_out, data_lane_1_out, data_lane_0_out} <=
                  out_byte[7:4];
                {data_lane_3_oe_n, data_lane_2_oe_n, data_lane_1_oe_n, data_lane_0_oe_n} <=
                  4'h0;
              end
            endcase
          end
          S_WDATA: if (rise) begin
            sr <= sh;
            cnt <= last_edge ? 5'd0 : cnt + 5'd1;
            // bytes past a full page are dropped rather than wrapped over
            if (last_edge && wcount != 9'h100) begin
              wr_valid <= 1'b1;
              wr_data <= sh[7:0];
              wcount <= wcount + 9'h001;
              wrote <= 1'b1;
              op_armed <= 1'b1;
            end
          end
          S_IDLE: st <= S_IDLE;
          S_DONE: st <= S_DONE;
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // apb register file
  reg [31:0] apb_rd;
  reg apb_miss;
  always @* begin
    apb_rd = 32'h00000000;
    apb_miss = 1'b0;
    case (paddr)
      `SFBF_OFF_CTRL: apb_rd = {21'h000000, ctrl};
      `SFBF_OFF_DUMMY: apb_rd = {16'h0000, dummy_cfg};
      `SFBF_OFF_STAT: apb_rd = {13'h0000, st, last_opc, 2'b00, cont_active,
        ~qe & lane_s[2], paused, armed, ~sel_n_s, busy};
      `SFBF_OFF_ADDR: apb_rd = {7'h00, mem_addr};
      `SFBF_OFF_UIDL: apb_rd = UID_VALUE[31:0];
      `SFBF_OFF_UIDH: apb_rd = UID_VALUE[63:32];
      default: apb_miss = 1'b1;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl <= `SFBF_CTRL_RST;
      dummy_cfg <= `SFBF_DUMMY_RST;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : apb_rd;
        pslverr <= apb_miss;
      end
      if (psel && penable && pready && pwrite && !pslverr) begin
        if (paddr == `SFBF_OFF_CTRL) begin
          // lock bits are one-time: they set, and only reset clears them
          ctrl <= {ctrl[10:8] | pwdata[10:8], pwdata[7:0]};
        end
        if (paddr == `SFBF_OFF_DUMMY) begin
          dummy_cfg <= pwdata[15:0];
        end
      end
    end
  end
endmodule // sfbf_front_end

// *** rtl/sfbf_sync.v ***
/*
  Two-stage synchroniser for a group of independent level signals.
  Assumes each bit is a slow level; bits are not kept coherent with each other.
*/
`timescale 1ns/1ps
module sfbf_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sfbf_sync

// *** verification/sfbf_ctl_model.sv ***
/*
  Bus controller model: select, mode 0 serial clock, lane 0 out, lane 1 in.
  Assumes the bench clock and lane levels resolved outside, pulled up when free.
*/
`timescale 1ns/1ps
module sfbf_ctl_model (
  input wire clk,
  output logic sclk_pin,
  output logic select_n_pin,
  output logic [3:0] ctl_d,
  output logic [3:0] ctl_oe,
  input wire [3:0] lane,
  output logic got,
  output logic [7:0] rx
);
  // ==========================================
  // serial phases of 6 clocks leave room for the pin synchronisers
  initial begin
    sclk_pin = 1'b0;
    select_n_pin = 1'b0;
    ctl_d = 4'h0;
    ctl_oe = 4'h0;
    got = 1'b0;
    rx = 8'h00;
  end
  task automatic half;
    repeat (6) @(posedge clk);
  endtask
  task automatic cmd(input logic [31:0] v, input int n);
    if (select_n_pin) begin
      select_n_pin <= 1'b0;
      half();
    end
    ctl_oe <= 4'h1;
    for (int i = n - 1; i >= 0; i--) begin
      ctl_d[0] <= v[i];
      half();
      sclk_pin <= 1'b1;
      half();
      sclk_pin <= 1'b0;
    end
  endtask
  task automatic rd(input int nb);
    for (int b = 0; b < nb; b++) begin
      for (int i = 0; i < 8; i++) begin
        half();
        sclk_pin <= 1'b1;
        rx <= {rx[6:0], lane[1]};
        half();
        sclk_pin <= 1'b0;
      end
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
    end
  endtask
  task automatic frame_end;
    half();
    select_n_pin <= 1'b1;
    ctl_oe <= 4'h0;
    half();
    half();
  endtask
endmodule // sfbf_ctl_model

// *** verification/sfbf_fe_asserts.sv ***
/*
  Checker for the front end: select, lane enables, apb wait and array port.
  Assumes binding into sfbf_front_end with internal op times of 8 or more.
*/
`timescale 1ns/1ps
module sfbf_fe_asserts (
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire select_n_pin,
  input wire data_lane_0_oe_n,
  input wire data_lane_1_oe_n,
  input wire data_lane_2_oe_n,
  input wire data_lane_3_oe_n,
  input wire [24:0] mem_addr,
  input wire wr_valid,
  input wire erase_start,
  input wire [2:0] erase_size,
  input wire busy
);
  // ==========================================
  // properties, one clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_desel_float: assert property (select_n_pin [*8] |->
    data_lane_0_oe_n && data_lane_1_oe_n && data_lane_2_oe_n && data_lane_3_oe_n)
    else $error("lane driven while deselected");
  a_lane_pairs: assert property ((!data_lane_0_oe_n |-> !data_lane_1_oe_n) and
    (!data_lane_3_oe_n |-> !data_lane_2_oe_n)) else $error("lane enables out of pairing");
  a_drive_select: assert property ($fell(data_lane_1_oe_n) |-> !$past(select_n_pin, 3))
    else $error("output enabled without select");
  a_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_erase_busy: assert property (erase_start |-> ##[1:2] busy)
    else $error("erase start without busy");
  a_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("internal operation cut short");
  a_page_wrap: assert property (wr_valid |=>
    mem_addr[7:0] == $past(mem_addr[7:0]) + 8'h01 && $stable(mem_addr[24:8]))
    else $error("program address left its page");
  a_erase_align: assert property (erase_start |->
    (erase_size == 3'h1 && mem_addr[11:0] == 12'h000) ||
    (erase_size == 3'h2 && mem_addr[14:0] == 15'h0000) ||
    (erase_size == 3'h3 && mem_addr[15:0] == 16'h0000) ||
    (erase_size == 3'h4 && mem_addr == 25'h0000000)) else $error("erase group misaligned");
  c_read: cover property (!data_lane_1_oe_n);
  c_prog: cover property (wr_valid);
  c_erase: cover property (erase_start ##[1:2] busy);
endmodule // sfbf_fe_asserts

bind sfbf_front_end sfbf_fe_asserts i_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pready(pready), .select_n_pin(select_n_pin),
  .data_lane_0_oe_n(data_lane_0_oe_n), .data_lane_1_oe_n(data_lane_1_oe_n),
  .data_lane_2_oe_n(data_lane_2_oe_n), .data_lane_3_oe_n(data_lane_3_oe_n),
  .mem_addr(mem_addr), .wr_valid(wr_valid), .erase_start(erase_start),
  .erase_size(erase_size), .busy(busy));

// *** verification/tb.sv ***
/*
  Self-checking bench of sfbf_front_end: apb registers, reads, program, erase.
  Assumes the controller model and a byte array answering mem_addr at once.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, seed = 32'd43672, a, d, m;
  logic [31:0] prdata;
  logic pready, pslverr, sclk, sel_n, got, busy, wr_valid, erase_start;
  logic [3:0] lane, outs, oe_n, cd, coe;
  logic [7:0] rx, wr_data;
  logic [24:0] mem_addr;
  logic [2:0] erase_size;
  logic [1:0] mem_region;
  logic [63:0] expq[$];
  int failures = 0, cmp_count = 0, cyc = 0;
  wire [7:0] mem_rdata = mem_addr[7:0] ^ 8'ha5;
  always #4 clk = ~clk;
  // ==========================================
  // wiring: a lane nobody drives reads high through its pull-up
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane[i] = !oe_n[i] ? outs[i] : coe[i] ? cd[i] : 1'b1;
  end
  sfbf_front_end #(.T_PROG_CYC(34'h14), .T_SECT_CYC(34'h14), .T_B32_CYC(34'h14),
    .T_B64_CYC(34'h14), .T_CHIP_CYC(34'h14)) i_dut (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_pin(sclk),
    .select_n_pin(sel_n), .data_lane_0_in(lane[0]), .data_lane_1_in(lane[1]),
    .data_lane_2_in(lane[2]), .data_lane_3_in(lane[3]), .data_lane_0_out(outs[0]),
    .data_lane_1_out(outs[1]), .data_lane_2_out(outs[2]), .data_lane_3_out(outs[3]),
    .data_lane_0_oe_n(oe_n[0]), .data_lane_1_oe_n(oe_n[1]), .data_lane_2_oe_n(oe_n[2]),
    .data_lane_3_oe_n(oe_n[3]), .mem_addr(mem_addr), .mem_region(mem_region),
    .mem_rdata(mem_rdata), .wr_valid(wr_valid), .wr_data(wr_data),
    .erase_start(erase_start), .erase_size(erase_size), .busy(busy));
  sfbf_ctl_model i_ctl (.clk(clk), .sclk_pin(sclk), .select_n_pin(sel_n), .ctl_d(cd),
    .ctl_oe(coe), .lane(lane), .got(got), .rx(rx));
  // ==========================================
  // tasks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_exp(input logic [11:0] ad, input logic [31:0] mk, input logic [31:0] e);
    expq.push_back({mk, e});
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic take(input string n, input logic [31:0] s);
    logic [63:0] q;
    if (expq.size() == 0) begin
      failures++;
      $display("[FAIL] %s expected nothing seen %h", n, s);
    end else begin
      q = expq.pop_front();
      `CHK(n, q[31:0], s & q[63:32])
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // result monitor and hang guard
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) take("apb read", {pslverr, prdata[30:0]});
    if (wr_valid) take("array write", {mem_addr[23:0], wr_data});
    if (erase_start) take("erase", {2'h0, mem_region, erase_size, mem_addr});
    if (got) take("serial read", {24'h0, rx});
    cyc++;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_exp(12'h008, 32'h4, 32'h0);
    i_ctl.frame_end();
    rd_exp(12'h008, 32'h4, 32'h4);
    rd_exp(12'h004, 32'hffff, 32'h4648);
    rd_exp(12'h03c, 32'hffffffff, 32'h80000000);
    a = xs() & 32'hffff;
    apb(1'b1, 12'h004, a);
    rd_exp(12'h004, 32'hffff, a);
    apb(1'b1, 12'h004, 32'h4648);
    $display("test registers done");
    a = xs() & 32'hfffff0;
    expq.push_back({32'hff, 24'h0, a[7:0] ^ 8'ha5});
    expq.push_back({32'hff, 24'h0, (a[7:0] + 8'h01) ^ 8'ha5});
    i_ctl.cmd({8'h0b, a[23:0]}, 32);
    i_ctl.cmd(32'h0, 8);
    i_ctl.rd(2);
    i_ctl.frame_end();
    apb(1'b1, 12'h000, 32'h8);
    a = xs() | 32'h7;
    expq.push_back({32'hff, 24'h0, a[7:0] ^ 8'ha5});
    expq.push_back({32'hff, 24'h0, (a[7:0] & 8'hf8) ^ 8'ha5});
    i_ctl.cmd({8'h0b, a[23:0]}, 32);
    i_ctl.cmd(32'h0, 8);
    i_ctl.rd(2);
    i_ctl.frame_end();
    apb(1'b1, 12'h000, 32'h0);
    $display("test fast read done");
    a = xs() | 32'hff;
    d = xs();
    expq.push_back({32'hffffffff, a[23:0], d[15:8]});
    expq.push_back({32'hffffffff, a[23:8], 8'h00, d[7:0]});
    i_ctl.cmd({8'h02, a[23:0]}, 32);
    i_ctl.cmd(d, 16);
    i_ctl.frame_end();
    rd_exp(12'h008, 32'h1, 32'h1);
    while (busy !== 1'b0) @(posedge clk);
    $display("test program done");
    for (int k = 0; k < 4; k++) begin
      a = xs() & 32'hffffff;
      m = k == 0 ? 32'hfff : k == 1 ? 32'h7fff : k == 2 ? 32'hffff : 32'hffffffff;
      d = k == 0 ? 32'h20 : k == 1 ? 32'h52 : k == 2 ? 32'hd8 : 32'hc7;
      expq.push_back({32'hffffffff, 4'h0, 3'(k + 1), 25'(a & ~m)});
      i_ctl.cmd(k == 3 ? d : {d[7:0], a[23:0]}, k == 3 ? 8 : 32);
      i_ctl.frame_end();
      while (busy !== 1'b0) @(posedge clk);
    end
    i_ctl.cmd({8'h20, 12'h000}, 20);
    i_ctl.frame_end();
    repeat (30) @(posedge clk);
    $display("test erase done");
    report_and_stop();
  end
endmodule // tb
